/* hw/mcu8_exec_params.svh */
// Opcode patterns, field positions and reset values for the execute unit
`ifndef MCU8_EXEC_PARAMS_SVH
`define MCU8_EXEC_PARAMS_SVH

// Full one-byte opcodes
`define OP_ACC_DEC        8'h07
`define OP_ACC_INC        8'h17
`define OP_EXT_IRQ_DIS    8'h15
`define OP_TMR_IRQ_DIS    8'h35
`define OP_EXT_IRQ_EN     8'h05
`define OP_TMR_IRQ_EN     8'h25
`define OP_TEST_CLK_OUT   8'h75
`define OP_BUS_READ       8'h08
`define OP_CARRY_SET_BR   8'hF6
`define OP_CARRY_CLR_BR   8'hE6
`define OP_FLAG_A_BR      8'hB6
`define OP_FLAG_B_BR      8'h76
`define OP_IRQ_LOW_BR     8'h86
`define OP_PAGE_IND_BR    8'hB3

// Opcodes with a field in the low bits (upper bits compared)
`define OP_REG_DEC_HI     5'h19
`define OP_REG_INC_HI     5'h03
`define OP_CNT_DOWN_HI    5'h1D
`define OP_MEM_INC_HI     7'h08
`define OP_PORT_IN_HI     6'h02

// Opcodes with a field in the high bits (low bits compared)
`define OP_ACC_BIT_LO     5'h12
`define OP_DIRECT_LO      5'h04

// Port selections of the port input opcode
`define PORT_SEL_ONE      2'h1
`define PORT_SEL_TWO      2'h2

// Reset values
`define PC_RESET          12'h000
`define ACC_RESET         8'h00
`define WREG_RESET        8'h00
`define READ_IDLE         1'b1

`endif

/* hw/mcu8_exec_pkg.sv */
// Types shared by the execute unit
package mcu8_exec_pkg;

    // Machine cycle within an instruction, Gray coded
    typedef enum logic [1:0] {
        CYCLE_ONE = 2'b00,
        CYCLE_TWO = 2'b01
    } cycle_t;

    typedef logic [7:0]  byte_t;
    typedef logic [11:0] addr_t;

endpackage : mcu8_exec_pkg

/* hw/pin_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
    parameter int          WIDTH      = 8,
    parameter logic [31:0] RESET_BITS = 32'h0000_0000
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pins,
    output logic      [WIDTH-1:0] synced
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= RESET_BITS[WIDTH-1:0];
            synced   <= RESET_BITS[WIDTH-1:0];
        end else begin
            meta_reg <= pins;
            synced   <= meta_reg;
        end
    end

endmodule : pin_sync

/* hw/mcu8_exec.sv */
// Execute unit: inc/dec, count-down branch, irq enables, port input, branches
`timescale 1ns/1ns
`include "mcu8_exec_params.svh"
module mcu8_exec #(
    parameter int DMEM_AW = 6
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    output mcu8_exec_pkg::addr_t      prog_addr,
    input  wire mcu8_exec_pkg::byte_t prog_data,
    input  wire logic                 carry_flag,
    input  wire logic                 user_flag_a,
    input  wire logic                 user_flag_b,
    input  wire logic                 memory_bank_choose,
    input  wire logic                 timer_overflow,
    input  wire logic                 timer_flag_clear,
    input  wire logic                 irq_taken,
    input  wire mcu8_exec_pkg::byte_t port1_pins,
    input  wire mcu8_exec_pkg::byte_t port2_pins,
    input  wire mcu8_exec_pkg::byte_t bus_pins,
    input  wire logic                 irq_pin_n,
    output logic                      read_strobe_n,
    output logic                      test_pin_zero_out,
    output logic                      test_pin_zero_oe,
    output mcu8_exec_pkg::byte_t      acc_out,
    output logic                      timer_flag,
    output logic                      ext_irq_enabled,
    output logic                      timer_irq_enabled,
    output logic                      timer_irq_pending,
    output logic                      irq_request
);
    import mcu8_exec_pkg::*;

    cycle_t       state_reg;
    addr_t        pc_reg;
    byte_t        op_reg;
    byte_t        acc_reg;
    byte_t        wreg [8];
    byte_t        dmem [2**DMEM_AW];
    logic         clk_out_en_reg;
    logic         clk_toggle_reg;
    byte_t        port1_sync;
    byte_t        port2_sync;
    byte_t        bus_sync;
    logic [0:0]   irq_sync;
    logic         in_one;
    logic         in_two;
    byte_t        cur_op;
    addr_t        pc_inc;
    logic         two_cycle;
    logic         is_cond;
    logic         cond_true;
    logic [2:0]   ridx;

    // Pin inputs pass two flip-flops before use
    pin_sync #(.WIDTH(8)) sync_p1 (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (port1_pins),
        .synced  (port1_sync)
    );
    pin_sync #(.WIDTH(8)) sync_p2 (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (port2_pins),
        .synced  (port2_sync)
    );
    pin_sync #(.WIDTH(8)) sync_bus (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (bus_pins),
        .synced  (bus_sync)
    );
    pin_sync #(.WIDTH(1), .RESET_BITS(32'h0000_0001)) sync_irq (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (irq_pin_n),
        .synced  (irq_sync)
    );

    // Opcode in view: fresh byte in cycle one, latched byte in cycle two
    assign in_one = (state_reg == CYCLE_ONE);
    assign in_two = (state_reg == CYCLE_TWO);
    assign cur_op = in_one ? prog_data : op_reg;
    assign ridx   = cur_op[2:0];
    assign pc_inc = {pc_reg[11], pc_reg[10:0] + 11'h001};

    // Page-indirect branch fetches its target from the current page
    assign prog_addr = (in_two && op_reg == `OP_PAGE_IND_BR)
                     ? {pc_reg[11:8], acc_reg} : pc_reg;

    // Which opcodes take a second machine cycle
    always_comb begin
        two_cycle = 1'b0;
        if (cur_op[7:3] == `OP_CNT_DOWN_HI || cur_op[4:0] == `OP_ACC_BIT_LO ||
            cur_op[4:0] == `OP_DIRECT_LO   || cur_op == `OP_PAGE_IND_BR ||
            cur_op == `OP_CARRY_SET_BR     || cur_op == `OP_CARRY_CLR_BR ||
            cur_op == `OP_FLAG_A_BR        || cur_op == `OP_FLAG_B_BR ||
            cur_op == `OP_IRQ_LOW_BR       || cur_op == `OP_BUS_READ ||
            (cur_op[7:2] == `OP_PORT_IN_HI &&
             (cur_op[1:0] == `PORT_SEL_ONE || cur_op[1:0] == `PORT_SEL_TWO))) begin
            two_cycle = 1'b1;
        end
    end

    // Branch condition of the latched conditional branch
    always_comb begin
        is_cond   = 1'b1;
        cond_true = 1'b0;
        if (op_reg[7:3] == `OP_CNT_DOWN_HI) begin
            cond_true = (wreg[op_reg[2:0]] != 8'h00);
        end else if (op_reg[4:0] == `OP_ACC_BIT_LO) begin
            cond_true = acc_reg[op_reg[7:5]];
        end else begin
            case (op_reg)
                `OP_CARRY_SET_BR: cond_true = carry_flag;
                `OP_CARRY_CLR_BR: cond_true = !carry_flag;
                `OP_FLAG_A_BR:    cond_true = user_flag_a;
                `OP_FLAG_B_BR:    cond_true = user_flag_b;
                `OP_IRQ_LOW_BR:   cond_true = !irq_sync[0];
                default:          is_cond   = 1'b0;
            endcase
        end
    end

    // Machine cycle sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= CYCLE_ONE;
            op_reg    <= 8'h00;
        end else begin
            case (state_reg)
                CYCLE_ONE: begin
                    if (two_cycle) begin
                        state_reg <= CYCLE_TWO;
                        op_reg    <= prog_data;
                    end
                end
                CYCLE_TWO: state_reg <= CYCLE_ONE;
                default:   state_reg <= CYCLE_ONE;
            endcase
        end
    end

    // Program counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg <= `PC_RESET;
        end else if (in_one) begin
            pc_reg <= pc_inc;
        end else if (op_reg[4:0] == `OP_DIRECT_LO) begin
            pc_reg <= {memory_bank_choose, op_reg[7:5], prog_data};
        end else if (op_reg == `OP_PAGE_IND_BR) begin
            pc_reg <= {pc_reg[11:8], prog_data};
        end else if (is_cond && cond_true) begin
            // Page taken after the first byte, so a page-end start lands one page on
            pc_reg <= {pc_reg[11:8], prog_data};
        end else if (is_cond) begin
            pc_reg <= pc_inc;
        end
    end

    // Accumulator; carry is never written here
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= `ACC_RESET;
        end else if (in_one && prog_data == `OP_ACC_DEC) begin
            acc_reg <= acc_reg - 8'h01;
        end else if (in_one && prog_data == `OP_ACC_INC) begin
            acc_reg <= acc_reg + 8'h01;
        end else if (in_two && op_reg == `OP_BUS_READ) begin
            acc_reg <= bus_sync;
        end else if (in_two && op_reg[7:2] == `OP_PORT_IN_HI) begin
            // Bus read shares the upper opcode bits, so it is decoded first
            acc_reg <= op_reg[1] ? port2_sync : port1_sync;
        end
    end
    assign acc_out = acc_reg;

    // Read strobe low through the second cycle of a bus read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_strobe_n <= `READ_IDLE;
        end else begin
            read_strobe_n <= !(in_one && prog_data == `OP_BUS_READ);
        end
    end

    // Working registers
    generate
        for (genvar i = 0; i < 8; i++) begin : g_wreg
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    wreg[i] <= `WREG_RESET;
                end else if (in_one && ridx == 3'(i)) begin
                    if (prog_data[7:3] == `OP_REG_DEC_HI ||
                        prog_data[7:3] == `OP_CNT_DOWN_HI) begin
                        wreg[i] <= wreg[i] - 8'h01;
                    end else if (prog_data[7:3] == `OP_REG_INC_HI) begin
                        wreg[i] <= wreg[i] + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // Internal data memory, incremented through pointer register 0 or 1
    always_ff @(posedge clk) begin
        if (reset_n && in_one && prog_data[7:1] == `OP_MEM_INC_HI) begin
            dmem[wreg[prog_data[0]][DMEM_AW-1:0]] <=
                dmem[wreg[prog_data[0]][DMEM_AW-1:0]] + 8'h01;
        end
    end

    // Interrupt enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_irq_enabled   <= 1'b0;
            timer_irq_enabled <= 1'b0;
        end else if (in_one) begin
            if (prog_data == `OP_EXT_IRQ_EN) begin
                ext_irq_enabled <= 1'b1;
            end else if (prog_data == `OP_EXT_IRQ_DIS) begin
                ext_irq_enabled <= 1'b0;
            end else if (prog_data == `OP_TMR_IRQ_EN) begin
                timer_irq_enabled <= 1'b1;
            end else if (prog_data == `OP_TMR_IRQ_DIS) begin
                timer_irq_enabled <= 1'b0;
            end
        end
    end

    // Timer flag always set by overflow; the set wins over a clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_flag <= 1'b0;
        end else if (timer_overflow) begin
            timer_flag <= 1'b1;
        end else if (timer_flag_clear) begin
            timer_flag <= 1'b0;
        end
    end

    // Pending timer request; disable clears it, otherwise set wins over taken
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_irq_pending <= 1'b0;
        end else if (in_one && prog_data == `OP_TMR_IRQ_DIS) begin
            timer_irq_pending <= 1'b0;
        end else if (timer_overflow && timer_irq_enabled) begin
            timer_irq_pending <= 1'b1;
        end else if (irq_taken) begin
            timer_irq_pending <= 1'b0;
        end
    end

    // Service request to the sequencer
    assign irq_request = (ext_irq_enabled && !irq_sync[0]) ||
                         (timer_irq_enabled && timer_irq_pending);

    // Test pin clock output, held off until enabled, cleared only by reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_out_en_reg <= 1'b0;
            clk_toggle_reg <= 1'b0;
        end else begin
            if (in_one && prog_data == `OP_TEST_CLK_OUT) begin
                clk_out_en_reg <= 1'b1;
            end
            clk_toggle_reg <= clk_out_en_reg && !clk_toggle_reg;
        end
    end
    assign test_pin_zero_oe  = clk_out_en_reg;
    assign test_pin_zero_out = clk_toggle_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    acc_dec_a: assert property (in_one && prog_data == `OP_ACC_DEC
        |=> acc_reg == $past(acc_reg) - 8'h01) else $error("acc decrement wrong");
    acc_inc_a: assert property (in_one && prog_data == `OP_ACC_INC
        |=> acc_reg == $past(acc_reg) + 8'h01) else $error("acc increment wrong");
    reg_dec_a: assert property (in_one && prog_data[7:3] == `OP_REG_DEC_HI
        |=> wreg[$past(ridx)] == $past(wreg[ridx]) - 8'h01)
        else $error("register decrement wrong");
    ext_mask_a: assert property (!ext_irq_enabled && !timer_irq_pending
        |-> !irq_request) else $error("masked pin raised request");
    ext_req_a: assert property (ext_irq_enabled && !irq_sync[0]
        |-> irq_request) else $error("pin low gave no request");
    tmr_dis_a: assert property (in_one && prog_data == `OP_TMR_IRQ_DIS
        |=> !timer_irq_pending && !timer_irq_enabled)
        else $error("timer disable left request");
    tmr_req_a: assert property (timer_irq_enabled && timer_overflow &&
        !(in_one && prog_data == `OP_TMR_IRQ_DIS) |=> irq_request)
        else $error("overflow gave no request");
    cnt_branch_a: assert property (in_two && op_reg[7:3] == `OP_CNT_DOWN_HI &&
        wreg[op_reg[2:0]] != 8'h00
        |=> pc_reg == {$past(pc_reg[11:8]), $past(prog_data)})
        else $error("count-down branch target wrong");
    skip_two_a: assert property (in_one && two_cycle && prog_data[4:0] != `OP_DIRECT_LO
        && prog_data != `OP_PAGE_IND_BR && prog_data[7:2] != `OP_PORT_IN_HI
        && prog_data != `OP_BUS_READ ##1 !cond_true
        |=> pc_reg == $past(pc_reg, 2) + 12'h002) else $error("untaken branch pc wrong");
    clk_out_a: assert property (test_pin_zero_oe |=> test_pin_zero_oe
        ##1 test_pin_zero_out != $past(test_pin_zero_out))
        else $error("test pin clock stalled");
    port_in_a: assert property (in_two && op_reg == 8'h09
        |=> acc_reg == $past(port1_sync)) else $error("port input wrong");
    direct_a: assert property (in_two && op_reg[4:0] == `OP_DIRECT_LO
        |=> pc_reg[10:0] == {$past(op_reg[7:5]), $past(prog_data)})
        else $error("direct branch wrong");

endmodule : mcu8_exec

/* tb/mcu8_far_side.sv */
// Far side model: program memory and the source on the strobed data bus
`timescale 1ns/1ns
module mcu8_far_side (
    input  wire mcu8_exec_pkg::addr_t prog_addr,
    input  wire logic                 read_strobe_n,
    output mcu8_exec_pkg::byte_t      prog_data,
    output mcu8_exec_pkg::byte_t      bus_pins
);
    import mcu8_exec_pkg::*;

    byte_t mem [0:4095];
    byte_t bus_val;
    logic  bus_held;

    // Program memory answers in the same cycle as the address
    assign prog_data = mem[prog_addr];

    // Source holds its byte until the strobe is removed, then shows junk
    assign bus_pins = bus_held ? bus_val : ~bus_val;

    // Strobe rising ends the hold time of the source
    always @(posedge read_strobe_n) begin
        bus_held = 1'b0;
    end

    initial begin
        bus_held = 1'b0;
        bus_val  = 8'h00;
    end

    // Fill the whole program memory with a harmless opcode
    task automatic wipe();
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    endtask : wipe

    // Present a new byte on the bus and hold it until the strobe rises
    task automatic load_bus(input byte_t v);
        bus_val  = v;
        bus_held = 1'b1;
    endtask : load_bus
endmodule : mcu8_far_side

/* tb/mcu8_exec_tb.sv */
// Self-checking testbench for the execute unit
`timescale 1ns/1ns
module mcu8_exec_tb;
    import mcu8_exec_pkg::*;

    logic  clk, reset_n, carry_flag, user_flag_a, user_flag_b, memory_bank_choose;
    logic  timer_overflow, timer_flag_clear, irq_taken, irq_pin_n, read_strobe_n;
    logic  test_pin_zero_out, test_pin_zero_oe, timer_flag, ext_irq_enabled;
    logic  timer_irq_enabled, timer_irq_pending, irq_request, v;
    byte_t port1_pins, port2_pins, bus_pins, prog_data, acc_out;
    addr_t prog_addr;
    int    failures, n_tests;

    mcu8_exec u_mcu8_exec (
        .clk(clk), .reset_n(reset_n), .prog_addr(prog_addr), .prog_data(prog_data),
        .carry_flag(carry_flag), .user_flag_a(user_flag_a), .user_flag_b(user_flag_b),
        .memory_bank_choose(memory_bank_choose), .timer_overflow(timer_overflow),
        .timer_flag_clear(timer_flag_clear), .irq_taken(irq_taken),
        .port1_pins(port1_pins), .port2_pins(port2_pins), .bus_pins(bus_pins),
        .irq_pin_n(irq_pin_n), .read_strobe_n(read_strobe_n),
        .test_pin_zero_out(test_pin_zero_out), .test_pin_zero_oe(test_pin_zero_oe),
        .acc_out(acc_out), .timer_flag(timer_flag), .ext_irq_enabled(ext_irq_enabled),
        .timer_irq_enabled(timer_irq_enabled), .timer_irq_pending(timer_irq_pending),
        .irq_request(irq_request)
    );

    mcu8_far_side u_mcu8_far_side (
        .prog_addr(prog_addr), .read_strobe_n(read_strobe_n),
        .prog_data(prog_data), .bus_pins(bus_pins)
    );

    // Clock of 40 ns period
    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // Reset for 12 cycles; the next edge executes address zero
    task automatic restart();
        reset_n = 1'b0;
        step(12);
        reset_n = 1'b1;
    endtask : restart

    task automatic ld4(input addr_t a, input byte_t b0, b1, b2, b3);
        u_mcu8_far_side.mem[a] = b0;
        u_mcu8_far_side.mem[a + 12'h001] = b1;
        u_mcu8_far_side.mem[a + 12'h002] = b2;
        u_mcu8_far_side.mem[a + 12'h003] = b3;
    endtask : ld4

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Accumulator decrement then two increments from the reset value
    task automatic t_acc();
        u_mcu8_far_side.wipe();
        ld4(12'h000, 8'h07, 8'h17, 8'h17, 8'h00);
        restart();
        step(1);
        chk("acc dec", 12'h0FF, 12'(acc_out));
        step(1);
        chk("acc inc wrap", 12'h000, 12'(acc_out));
        step(1);
        chk("acc inc", 12'h001, 12'(acc_out));
        $display("t_acc done");
    endtask : t_acc

    // Two idle cycles fill the pin synchronisers, then both ports and a bus read
    task automatic t_port();
        u_mcu8_far_side.wipe();
        ld4(12'h000, 8'h00, 8'h00, 8'h09, 8'h0A);
        ld4(12'h004, 8'h08, 8'h00, 8'h00, 8'h00);
        restart();
        u_mcu8_far_side.load_bus(8'h5A);
        step(4);
        chk("port one", 12'h0A5, 12'(acc_out));
        step(2);
        chk("port two", 12'h03C, 12'(acc_out));
        step(1);
        chk("strobe low", 12'h000, 12'(read_strobe_n));
        chk("acc held", 12'h03C, 12'(acc_out));
        step(1);
        chk("bus read", 12'h05A, 12'(acc_out));
        chk("strobe high", 12'h001, 12'(read_strobe_n));
        $display("t_port done");
    endtask : t_port

    // Branch at address 3 with target 40h; untaken lands on 5
    task automatic t_br(input byte_t op, input byte_t pre, input logic taken);
        u_mcu8_far_side.wipe();
        ld4(12'h000, pre, 8'h00, 8'h00, op);
        ld4(12'h004, 8'h40, 8'h00, 8'h00, 8'h00);
        restart();
        step(5);
        chk("branch pc", taken ? 12'h040 : 12'h005, prog_addr);
    endtask : t_br

    // Every accumulator bit with bit 0 high only and with all bits high, and each condition input at both levels
    task automatic t_branches();
        for (int b = 0; b < 8; b++) begin
            t_br({b[2:0], 5'h12}, 8'h17, b == 0);
            t_br({b[2:0], 5'h12}, 8'h07, 1'b1);
        end
        for (int c = 0; c < 2; c++) begin
            carry_flag = c[0];
            user_flag_a = c[0];
            user_flag_b = c[0];
            irq_pin_n = ~c[0];
            t_br(8'hF6, 8'h00, c[0]);
            t_br(8'hE6, 8'h00, ~c[0]);
            t_br(8'hB6, 8'h00, c[0]);
            t_br(8'h76, 8'h00, c[0]);
            t_br(8'h86, 8'h00, c[0]);
        end
        irq_pin_n = 1'b1;
        $display("t_branches done");
    endtask : t_branches

    // Count-down branch after register decrement, increment and at a page end
    task automatic t_count();
        u_mcu8_far_side.wipe();
        ld4(12'h000, 8'hCA, 8'hEA, 8'h40, 8'h00);
        restart();
        step(3);
        chk("count down taken", 12'h040, prog_addr);
        ld4(12'h000, 8'h19, 8'hE9, 8'h40, 8'h00);
        restart();
        step(3);
        chk("count down falls", 12'h003, prog_addr);
        ld4(12'h000, 8'h04, 8'hFF, 8'h00, 8'h00);
        ld4(12'h0FF, 8'hEB, 8'h20, 8'h00, 8'h00);
        restart();
        step(4);
        chk("page end target", 12'h120, prog_addr);
        $display("t_count done");
    endtask : t_count

    // Direct branch with the bank bit set, then a page indirect branch
    task automatic t_jump();
        u_mcu8_far_side.wipe();
        memory_bank_choose = 1'b1;
        ld4(12'h000, 8'hE4, 8'h34, 8'h00, 8'h00);
        restart();
        step(2);
        chk("direct branch", 12'hF34, prog_addr);
        memory_bank_choose = 1'b0;
        ld4(12'h000, 8'h07, 8'hB3, 8'h00, 8'h00);
        ld4(12'h0FF, 8'h77, 8'h00, 8'h00, 8'h00);
        restart();
        step(2);
        chk("indirect fetch", 12'h0FF, prog_addr);
        step(1);
        chk("indirect branch", 12'h077, prog_addr);
        $display("t_jump done");
    endtask : t_jump

    // Interrupt enables and disables against the pin and timer overflow
    task automatic t_irq();
        u_mcu8_far_side.wipe();
        ld4(12'h000, 8'h05, 8'h00, 8'h00, 8'h15);
        ld4(12'h004, 8'h25, 8'h00, 8'h35, 8'h00);
        irq_pin_n = 1'b0;
        restart();
        step(3);
        chk("pin request", 12'h001, 12'(irq_request));
        chk("ext enabled", 12'h001, 12'(ext_irq_enabled));
        step(1);
        chk("pin ignored", 12'h000, 12'(irq_request));
        chk("ext disabled", 12'h000, 12'(ext_irq_enabled));
        irq_pin_n = 1'b1;
        step(1);
        chk("timer enabled", 12'h001, 12'(timer_irq_enabled));
        timer_overflow = 1'b1;
        step(1);
        timer_overflow = 1'b0;
        chk("timer request", 12'h001, 12'(irq_request));
        step(1);
        chk("pending cleared", 12'h000, 12'(timer_irq_pending));
        timer_flag_clear = 1'b1;
        step(1);
        timer_flag_clear = 1'b0;
        timer_overflow = 1'b1;
        step(1);
        timer_overflow = 1'b0;
        chk("flag still set", 12'h001, 12'(timer_flag));
        chk("no timer request", 12'h000, 12'(irq_request));
        $display("t_irq done");
    endtask : t_irq

    // Clock output on the test pin, removed again by reset
    task automatic t_clk();
        u_mcu8_far_side.wipe();
        ld4(12'h000, 8'h75, 8'h00, 8'h00, 8'h00);
        restart();
        step(1);
        chk("clock out enable", 12'h001, 12'(test_pin_zero_oe));
        v = test_pin_zero_out;
        step(1);
        chk("clock out toggle", 12'(!v), 12'(test_pin_zero_out));
        restart();
        chk("reset disables", 12'h000, 12'(test_pin_zero_oe));
        $display("t_clk done");
    endtask : t_clk

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog well beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[FAIL] watchdog expected end seen hang");
        close_out();
    end

    // Main sequence
    initial begin
        failures = 0;
        n_tests = 0;
        reset_n = 1'b0;
        carry_flag = 1'b0;
        user_flag_a = 1'b0;
        user_flag_b = 1'b0;
        memory_bank_choose = 1'b0;
        timer_overflow = 1'b0;
        timer_flag_clear = 1'b0;
        irq_taken = 1'b0;
        irq_pin_n = 1'b1;
        port1_pins = 8'hA5;
        port2_pins = 8'h3C;
        t_acc();
        t_port();
        t_branches();
        t_count();
        t_jump();
        t_irq();
        t_clk();
        close_out();
    end
endmodule : mcu8_exec_tb
